//--- rtl/ipv_prio_ctrl.sv
// Priority registers, request arbitration and test/status readback.
// Assumes flags and enables come from outside and the core acknowledges
// and returns with one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
`include "ipv_defines.svh"
module ipv_prio_ctrl import ipv_pkg::*; (
	input wire logic mclk, // System clock, 100 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic [3:0] regAddr, // Register word index.
	input wire logic [15:0] regWdata, // Write data.
	input wire logic regWr, // Write strobe.
	input wire logic regRd, // Read strobe.
	output logic [15:0] regRdata, // Read data, cycle after strobe.
	input wire logic [15:0] srcFlag, // Source flag bits.
	input wire logic [15:0] srcEnable, // Source enable bits.
	input wire logic [3:0] trapFlag, // Trap request lines.
	input wire logic [3:0] cpuLevel, // Current CPU priority level.
	input wire logic ackPulse, // Core takes the presented request.
	input wire logic retPulse, // Return-from-interrupt completes.
	output ipv_req_s coreReq, // Prioritised request to the core.
	output logic irqOut // Level interrupt from status bits.
);

	logic [2:0] prio_reg [0:`IPV_NSRC-1];
	logic capMode_reg;
	logic nestDis_reg;
	logic [6:0] lastVec_reg;
	logic [3:0] savedLvl_reg;
	ipv_state_e state_reg;
	logic [1:0] stat_reg;
	logic [1:0] mask_reg;
	logic [15:0] field [0:6];
	logic [3:0] srcLvl [0:`IPV_NSRC-1];
	logic [3:0] bestLvl;
	logic [6:0] bestVec;
	logic bestValid;
	logic [3:0] effLvl;
	logic pendBlocked;
	logic grant;
	logic [15:0] rdNext;

	// Each source's effective level; code zero never requests.
	genvar gi;
	generate
		for (gi = 0; gi < `IPV_NSRC; gi = gi + 1) begin : g_src
			assign srcLvl[gi] = (srcFlag[gi] && srcEnable[gi] &&
				prio_reg[gi] != 3'h0) ? {1'b0, prio_reg[gi]} : 4'h0;
		end
	endgenerate

	// Pick the highest request; traps sit above every user level.
	always_comb begin
		bestLvl = 4'h0;
		bestVec = 7'h00;
		bestValid = 1'b0;
		for (int i = 0; i < `IPV_NSRC; i++) begin
			if (srcLvl[i] > bestLvl) begin
				bestLvl = srcLvl[i];
				bestVec = 7'(i + `IPV_NTRAP + 4);
				bestValid = 1'b1;
			end
		end
		for (int t = 0; t < `IPV_NTRAP; t++) begin
			if (trapFlag[t]) begin
				bestLvl = 4'(`IPV_TRAP_LVL + t);
				bestVec = 7'(t);
				bestValid = 1'b1;
			end
		end
	end

	// While serving with nesting off, only traps may break in.
	assign effLvl = (nestDis_reg && state_reg == IPV_SERVE) ?
		4'h7 : cpuLevel;
	assign grant = bestValid && bestLvl > effLvl;
	assign pendBlocked = bestValid && !grant;
	assign coreReq = '{valid: grant, level: bestLvl, vector: bestVec};

	// Priority fields, loaded to level four at reset.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `IPV_NSRC; i++)
				prio_reg[i] <= `IPV_PRIO_RESET;
		end else if (regWr) begin
			unique case (regAddr)
				`IPV_ADDR_LOWVOLT: prio_reg[0] <= regWdata[2:0];
				`IPV_ADDR_CHARGE: prio_reg[1] <= regWdata[6:4];
				`IPV_ADDR_UART3: begin
					prio_reg[2] <= regWdata[14:12];
					prio_reg[3] <= regWdata[10:8];
					prio_reg[4] <= regWdata[6:4];
				end
				`IPV_ADDR_U4E_USB: begin
					prio_reg[5] <= regWdata[14:12];
					prio_reg[6] <= regWdata[10:8];
					prio_reg[7] <= regWdata[6:4];
					prio_reg[8] <= regWdata[2:0];
				end
				`IPV_ADDR_SPI3_U4: begin
					prio_reg[9] <= regWdata[14:12];
					prio_reg[10] <= regWdata[10:8];
					prio_reg[11] <= regWdata[6:4];
					prio_reg[12] <= regWdata[2:0];
				end
				`IPV_ADDR_CAPCMP9: begin
					prio_reg[13] <= regWdata[6:4];
					prio_reg[14] <= regWdata[2:0];
				end
				default: ;
			endcase
		end
	end

	// Capture mode, nesting disable and the interrupt mask.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			capMode_reg <= 1'b0;
			nestDis_reg <= 1'b0;
			mask_reg <= 2'h0;
		end else if (regWr) begin
			if (regAddr == `IPV_ADDR_TEST)
				capMode_reg <= regWdata[`IPV_POS_CAPMODE];
			if (regAddr == `IPV_ADDR_GCTRL)
				nestDis_reg <= regWdata[`IPV_POS_NEST];
			if (regAddr == `IPV_ADDR_IRQMASK)
				mask_reg <= regWdata[1:0];
		end
	end

	// Service tracking; the interrupted level is kept, the core restores it on return.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= IPV_IDLE;
			savedLvl_reg <= 4'h0;
			lastVec_reg <= 7'h00;
		end else begin
			if (grant && ackPulse) begin
				state_reg <= IPV_SERVE;
				savedLvl_reg <= cpuLevel;
				lastVec_reg <= bestVec;
			end else if (retPulse) begin
				// A still-set flag requests again straight away.
				state_reg <= IPV_IDLE;
			end
		end
	end

	// Sticky events: grant taken, and request blocked. Set beats read.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			stat_reg <= 2'h0;
		else
			stat_reg <= ((regRd && regAddr == `IPV_ADDR_IRQSTAT) ?
				2'h0 : stat_reg) | {pendBlocked, grant && ackPulse};
	end
	assign irqOut = |(stat_reg & mask_reg);

	// Readback images with unimplemented bits at zero.
	always_comb begin
		field[0] = {13'h0000, prio_reg[0]};
		field[1] = {9'h000, prio_reg[1], 4'h0};
		field[2] = {1'b0, prio_reg[2], 1'b0, prio_reg[3], 1'b0,
			prio_reg[4], 4'h0};
		field[3] = {1'b0, prio_reg[5], 1'b0, prio_reg[6], 1'b0,
			prio_reg[7], 1'b0, prio_reg[8]};
		field[4] = {1'b0, prio_reg[9], 1'b0, prio_reg[10], 1'b0,
			prio_reg[11], 1'b0, prio_reg[12]};
		field[5] = {9'h000, prio_reg[13], 1'b0, prio_reg[14]};
		field[6] = {pendBlocked, 1'b0, capMode_reg, 1'b0,
			cpuLevel, 1'b0,
			capMode_reg ? bestVec : lastVec_reg};
	end

	// Read mux; unmapped indices answer zero.
	always_comb begin
		rdNext = 16'h0000;
		if (regAddr <= `IPV_ADDR_TEST)
			rdNext = field[regAddr[2:0]];
		else if (regAddr == `IPV_ADDR_GCTRL)
			rdNext = {nestDis_reg, 15'h0000};
		else if (regAddr == `IPV_ADDR_IRQSTAT)
			rdNext = {14'h0000, stat_reg};
		else if (regAddr == `IPV_ADDR_IRQMASK)
			rdNext = {14'h0000, mask_reg};
	end

	// Read data is registered and held only for the cycle after a read.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			regRdata <= 16'h0000;
		else
			regRdata <= regRd ? rdNext : 16'h0000;
	end

	// The core restores the level on return; the block keeps a copy of
	// the level it interrupted so that the hand-over can be checked.
	property p_save_lvl;
		@(posedge mclk) disable iff (!reset_n)
		(grant && ackPulse) |=> savedLvl_reg == $past(cpuLevel);
	endproperty
	a_save_lvl: assert property (p_save_lvl)
		else $error("interrupted level not kept");

	property p_reset_prio;
		@(posedge mclk) disable iff (!reset_n)
		$rose(reset_n) |-> prio_reg[0] == 3'h4;
	endproperty
	a_reset_prio: assert property (p_reset_prio)
		else $error("priority not four after reset");

	property p_zero_never;
		@(posedge mclk) disable iff (!reset_n)
		(prio_reg[0] == 3'h0) |-> srcLvl[0] == 4'h0;
	endproperty
	a_zero_never: assert property (p_zero_never)
		else $error("disabled source requests");

	property p_need_en;
		@(posedge mclk) disable iff (!reset_n)
		!srcEnable[3] |-> srcLvl[3] == 4'h0;
	endproperty
	a_need_en: assert property (p_need_en)
		else $error("request without enable");

	property p_rd_zero;
		@(posedge mclk) disable iff (!reset_n)
		(regRd && regAddr == `IPV_ADDR_LOWVOLT) |=> regRdata[15:3] == 13'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("unimplemented bits read nonzero");

	property p_wr_u3;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_UART3) |=>
			prio_reg[2] == $past(regWdata[14:12]);
	endproperty
	a_wr_u3: assert property (p_wr_u3)
		else $error("uart3 tx field misplaced");

	property p_trap;
		@(posedge mclk) disable iff (!reset_n)
		(trapFlag != 4'h0 && cpuLevel < `IPV_TRAP_LVL) |-> grant;
	endproperty
	a_trap: assert property (p_trap)
		else $error("trap masked");

	property p_pend;
		@(posedge mclk) disable iff (!reset_n)
		(regRd && regAddr == `IPV_ADDR_TEST) |=>
			regRdata[15] == $past(pendBlocked) &&
			regRdata[11:8] == $past(cpuLevel);
	endproperty
	a_pend: assert property (p_pend)
		else $error("test register status wrong");

	property p_nest;
		@(posedge mclk) disable iff (!reset_n)
		(nestDis_reg && state_reg == IPV_SERVE && trapFlag == 4'h0)
			|-> !grant;
	endproperty
	a_nest: assert property (p_nest)
		else $error("preempted with nesting disabled");

	// Each field takes its value from its own bit positions only.
	property p_wr_lowvolt;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_LOWVOLT) |=>
			prio_reg[0] == $past(regWdata[2:0]);
	endproperty
	a_wr_lowvolt: assert property (p_wr_lowvolt)
		else $error("low-voltage field misplaced");

	property p_wr_charge;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_CHARGE) |=>
			prio_reg[1] == $past(regWdata[6:4]);
	endproperty
	a_wr_charge: assert property (p_wr_charge)
		else $error("charge-measure field misplaced");

	property p_wr_u4e;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_U4E_USB) |=>
			prio_reg[5] == $past(regWdata[14:12]) &&
			prio_reg[8] == $past(regWdata[2:0]);
	endproperty
	a_wr_u4e: assert property (p_wr_u4e)
		else $error("uart4 error or i2c3 slave field misplaced");

	property p_wr_spi3;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_SPI3_U4) |=>
			prio_reg[9] == $past(regWdata[14:12]) &&
			prio_reg[12] == $past(regWdata[2:0]);
	endproperty
	a_wr_spi3: assert property (p_wr_spi3)
		else $error("spi3 event or uart4 rx field misplaced");

	property p_wr_cap9;
		@(posedge mclk) disable iff (!reset_n)
		(regWr && regAddr == `IPV_ADDR_CAPCMP9) |=>
			prio_reg[13] == $past(regWdata[6:4]) &&
			prio_reg[14] == $past(regWdata[2:0]);
	endproperty
	a_wr_cap9: assert property (p_wr_cap9)
		else $error("capture9 or compare9 field misplaced");

	// Fields in the later registers start at level four as well.
	property p_reset_far;
		@(posedge mclk) disable iff (!reset_n)
		$rose(reset_n) |-> prio_reg[9] == `IPV_PRIO_RESET &&
			prio_reg[14] == `IPV_PRIO_RESET;
	endproperty
	a_reset_far: assert property (p_reset_far)
		else $error("later priority fields not four after reset");

	// The gaps between test register fields always read as zero.
	property p_test_gaps;
		@(posedge mclk) disable iff (!reset_n)
		(regRd && regAddr == `IPV_ADDR_TEST) |=>
			{regRdata[14], regRdata[12], regRdata[7]} == 3'h0;
	endproperty
	a_test_gaps: assert property (p_test_gaps)
		else $error("test register gap bits nonzero");

	property p_vec_mode;
		@(posedge mclk) disable iff (!reset_n)
		(regRd && regAddr == `IPV_ADDR_TEST) |=>
			regRdata[6:0] == ($past(capMode_reg) ?
			$past(bestVec) : $past(lastVec_reg));
	endproperty
	a_vec_mode: assert property (p_vec_mode)
		else $error("vector number from wrong source");

	property p_ack_vec;
		@(posedge mclk) disable iff (!reset_n)
		(grant && ackPulse) |=> lastVec_reg == $past(bestVec);
	endproperty
	a_ack_vec: assert property (p_ack_vec)
		else $error("taken vector not captured");

	// A return frees the block at once, so a flag left set asks again.
	property p_ret_idle;
		@(posedge mclk) disable iff (!reset_n)
		(state_reg == IPV_SERVE && retPulse && !ackPulse) |=>
			state_reg == IPV_IDLE;
	endproperty
	a_ret_idle: assert property (p_ret_idle)
		else $error("service not ended on return");

	property p_trap_vec;
		@(posedge mclk) disable iff (!reset_n)
		trapFlag[3] |-> bestVec == 7'h03 &&
			bestLvl == 4'(`IPV_TRAP_LVL + 3);
	endproperty
	a_trap_vec: assert property (p_trap_vec)
		else $error("highest trap not chosen");

	// A blocked request is recorded even when status is read that cycle.
	property p_stat_set;
		@(posedge mclk) disable iff (!reset_n)
		pendBlocked |=> stat_reg[1];
	endproperty
	a_stat_set: assert property (p_stat_set)
		else $error("blocked request not recorded");

	property p_need_flag;
		@(posedge mclk) disable iff (!reset_n)
		!srcFlag[9] |-> srcLvl[9] == 4'h0;
	endproperty
	a_need_flag: assert property (p_need_flag)
		else $error("request without flag");
endmodule : ipv_prio_ctrl

//--- rtl/ipv_defines.svh
// Constants for the interrupt priority and vector status block.
// Assumes a 16-bit register port with word indices as addresses.
`ifndef IPV_DEFINES_SVH
`define IPV_DEFINES_SVH
`define IPV_ADDR_LOWVOLT 4'h0
`define IPV_ADDR_CHARGE 4'h1
`define IPV_ADDR_UART3 4'h2
`define IPV_ADDR_U4E_USB 4'h3
`define IPV_ADDR_SPI3_U4 4'h4
`define IPV_ADDR_CAPCMP9 4'h5
`define IPV_ADDR_TEST 4'h6
`define IPV_ADDR_GCTRL 4'h7
`define IPV_ADDR_IRQSTAT 4'h8
`define IPV_ADDR_IRQMASK 4'h9
`define IPV_PRIO_RESET 3'h4
`define IPV_NSRC 16
`define IPV_NTRAP 4
`define IPV_POS_PEND 15
`define IPV_POS_CAPMODE 13
`define IPV_POS_NEST 15
`define IPV_TRAP_LVL 4'h8
`endif

//--- rtl/ipv_pkg.sv
// Types shared by the interrupt priority and vector status block.
// Assumes the defines header is available on the include path.
package ipv_pkg;
	typedef logic [2:0] ipv_prio_t;
	typedef logic [3:0] ipv_lvl_t;
	typedef logic [6:0] ipv_vec_t;
	// Request presented to the processor core.
	typedef struct packed {
		logic valid;
		ipv_lvl_t level;
		ipv_vec_t vector;
	} ipv_req_s;
	typedef enum logic [1:0] {
		IPV_IDLE = 2'b00,
		IPV_SERVE = 2'b01
	} ipv_state_e;
endpackage : ipv_pkg

//--- tb/ipv_core_model.sv
// Behavioural processor core that takes prioritised requests.
// Assumes one mclk domain and the request struct of the package.
`timescale 1ns/1ps
module ipv_core_model import ipv_pkg::*; #(parameter int SVC = 40) (
	input wire logic mclk, // System clock.
	input wire logic reset_n, // Reset, active low.
	input wire ipv_req_s coreReq, // Request from the block.
	input wire logic ackEn, // Take requests while high.
	input wire ipv_lvl_t baseLevel, // Level while idle.
	output logic ackPulse, // Request taken.
	output logic retPulse, // Service routine done.
	output ipv_lvl_t cpuLevel // Current priority level.
);
	logic busy;
	int cnt;
	ipv_lvl_t saved;
	// The request is taken in the cycle it is shown, so the block sees
	// the acknowledge beside its own grant.
	assign ackPulse = !busy && ackEn && coreReq.valid;
	// One request at a time; a request shown while busy waits until the return.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			{retPulse, busy, cpuLevel, saved} <= '0;
			cnt <= 0;
		end else begin
			retPulse <= 1'h0;
			if (!busy) begin
				cpuLevel <= baseLevel;
				if (ackPulse) begin
					busy <= 1'h1;
					cnt <= SVC;
					saved <= baseLevel;
					cpuLevel <= coreReq.level;
				end
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end else begin
				retPulse <= 1'h1;
				busy <= 1'h0;
				cpuLevel <= saved;
			end
		end
	end
endmodule : ipv_core_model

//--- tb/test_interrupt_priority_and_vector_status.sv
// Self-checking bench for the priority and vector status block.
// Assumes the package and the core model are compiled first.
`timescale 1ns/1ps
module test_interrupt_priority_and_vector_status import ipv_pkg::*;;
	logic mclk = 1'h0, reset_n = 1'h0, regWr = 1'h0, regRd = 1'h0;
	logic ackEn = 1'h0, ackPulse, retPulse, irqOut, pend;
	logic [3:0] regAddr = 4'h0, trapFlag = 4'h0, t;
	logic [15:0] regWdata = 16'h0, srcFlag = 16'h0, srcEnable = 16'h0;
	logic [15:0] regRdata, d, f, en, m;
	ipv_lvl_t cpuLevel, baseLevel = 4'h0, lv;
	ipv_req_s coreReq, e;
	logic [15:0] sh [6];
	int bad_count = 0, checks = 0;
	localparam logic [15:0] MSK [6] = '{16'h0007, 16'h0070, 16'h7770,
		16'h7777, 16'h7777, 16'h0077};
	localparam int RI [15] = '{0, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 5, 5};
	localparam int SH [15] = '{0, 4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0, 4, 0};
	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;
	ipv_prio_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .srcFlag(srcFlag), .srcEnable(srcEnable),
		.trapFlag(trapFlag), .cpuLevel(cpuLevel), .ackPulse(ackPulse),
		.retPulse(retPulse), .coreReq(coreReq), .irqOut(irqOut));
	ipv_core_model u_core (.mclk(mclk), .reset_n(reset_n), .coreReq(coreReq),
		.ackEn(ackEn), .baseLevel(baseLevel), .ackPulse(ackPulse),
		.retPulse(retPulse), .cpuLevel(cpuLevel));
	task automatic chk(input logic [15:0] got, exp, input string msg);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= v;
		@(posedge mclk);
		regWr <= 1'h0;
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'h0;
		#1 d = regRdata;
	endtask : rd
	// Bounded wait for a core pulse, looked at between clock edges where
	// it has settled; running out ends the run.
	task automatic waitp(input bit ret, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			if (ret ? retPulse === 1'h1 : ackPulse === 1'h1) break;
			@(negedge mclk);
		end
		checks++;
		if (n == lim) begin
			bad_count++;
			$display("[FAIL] %0t core pulse missing", $time);
			complete_run();
		end
	endtask : waitp
	// Expected winner; strict compare keeps the lowest index on ties.
	function automatic ipv_req_s best(input logic [15:0] fl, ef,
		input logic [3:0] tf);
		ipv_req_s r;
		logic [2:0] p;
		r = '0;
		for (int i = 0; i < 15; i++) begin
			p = 3'(sh[RI[i]] >> SH[i]);
			if (fl[i] && ef[i] && p > r.level[2:0]) r = '{1'h1, {1'h0, p}, 7'(i + 8)};
		end
		for (int k = 0; k < 4; k++) if (tf[k]) r = '{1'h1, 4'(8 + k), 7'(k)};
		return r;
	endfunction : best
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	// Reset, register map, random arbitration, then a served request.
	initial begin
		void'($urandom(32'h78B29FE7));
		repeat (10) @(posedge mclk);
		reset_n <= 1'h1;
		for (int a = 0; a < 7; a++) begin
			rd(4'(a));
			chk(d, (a < 6) ? 16'h4444 & MSK[a] : 16'h0, "reset value");
			wr(4'(a), 16'hFFFF);
			rd(4'(a));
			chk(d, (a < 6) ? MSK[a] : 16'h2000, "writable bits");
		end
		wr(4'hC, 16'hFFFF);
		rd(4'hC);
		chk(d, 16'h0, "unmapped read");
		for (int it = 0; it < 40; it++) begin
			for (int a = 0; a < 6; a++) begin
				sh[a] = (it == 0) ? 16'h7777 : 16'($urandom);
				wr(4'(a), sh[a]);
				sh[a] &= MSK[a];
			end
			// Flag 15's priority field cannot be written and stays at four, so random draws leave it low.
			f = (it == 0) ? 16'hFFFF : 16'($urandom) & 16'h7FFF;
			en = (it == 0) ? 16'hFFFF : 16'($urandom);
			t = ($urandom % 4 == 0) ? 4'($urandom) : 4'h0;
			lv = 4'($urandom % 8);
			srcFlag <= f;
			srcEnable <= en;
			trapFlag <= t;
			baseLevel <= lv;
			repeat (3) @(posedge mclk);
			#1 e = best(f, en, t);
			pend = e.valid && !(e.level > lv);
			chk(16'(coreReq.valid), 16'(e.valid && e.level > lv), "valid");
			if (e.valid && e.level > lv) chk(16'(coreReq), 16'(e), "winner");
			rd(4'h6);
			m = e.valid ? 16'hFFFF : 16'hFF80;
			chk(d & m, {pend, 3'h2, lv, 1'h0, e.vector} & m, "test reg");
		end
		srcFlag <= 16'h0;
		trapFlag <= 4'h0;
		baseLevel <= 4'h0;
		srcEnable <= 16'hFFFF;
		wr(4'h6, 16'h0);
		for (int a = 0; a < 6; a++) wr(4'(a), (a == 2) ? 16'h2000 : (a == 5) ? 16'h0060 : 16'h0);
		wr(4'h9, 16'h0);
		rd(4'h8);
		ackEn <= 1'h1;
		srcFlag <= 16'h0004;
		waitp(0, 10);
		repeat (2) @(posedge mclk);
		#1 chk(16'(irqOut), 16'h0, "masked interrupt");
		wr(4'h9, 16'h0003);
		#1 chk(16'(irqOut), 16'h1, "unmasked interrupt");
		rd(4'h6);
		chk(d, 16'h820A, "acked vector");
		wr(4'h7, 16'h8000);
		srcFlag <= 16'h2004;
		repeat (2) @(posedge mclk);
		#1 chk(16'(coreReq.valid), 16'h0, "nesting blocked");
		wr(4'h7, 16'h0);
		#1 chk(16'(coreReq), 16'({1'h1, 4'h6, 7'h15}), "nesting open");
		srcFlag <= 16'h0004;
		waitp(1, 60);
		waitp(0, 3);
		@(posedge mclk);
		srcFlag <= 16'h0;
		waitp(1, 60);
		ackEn <= 1'h0;
		rd(4'h8);
		chk(d & 16'h0001, 16'h0001, "grant status");
		rd(4'h8);
		chk(d, 16'h0, "status cleared");
		chk(16'(irqOut), 16'h0, "interrupt cleared");
		complete_run();
	end
endmodule : test_interrupt_priority_and_vector_status
